//--- include/umlc_pkg.sv
// Register map, fields, timing and carrier types of the channel block.
package umlc_pkg;

   // Register offsets.
   localparam logic [7:0] MODE_ONE_OFS  = 8'h09;
   localparam logic [7:0] MODE_TWO_OFS  = 8'h0a;
   localparam logic [7:0] LINE_FMT_OFS  = 8'h0b;

   // Reset values.
   localparam logic [7:0] MODE_ONE_RST  = 8'h00;
   localparam logic [7:0] MODE_TWO_RST  = 8'h00;
   localparam logic [7:0] LINE_FMT_RST  = 8'h05;

   // Writable bits of mode one.
   localparam logic [7:0] MODE_ONE_MASK = 8'h9f;

   // Mode one fields.
   localparam int M1_IRQ_SEL   = 7;
   localparam int M1_AUTO_DIR  = 4;
   localparam int M1_RTS_FLOAT = 3;
   localparam int M1_TX_FLOAT  = 2;
   localparam int M1_TX_INHIB  = 1;
   localparam int M1_RX_INHIB  = 0;

   // Mode two fields.
   localparam int M2_ECHO_BLANK = 7;
   localparam int M2_NINE_BIT   = 6;
   localparam int M2_LOOPBACK   = 5;
   localparam int M2_MATCH_EN   = 4;
   localparam int M2_EMPTY_INV  = 3;
   localparam int M2_TRIG_INV   = 2;
   localparam int M2_FLUSH      = 1;
   localparam int M2_CHAN_RST   = 0;

   // Line format fields.
   localparam int LF_RTS_LEVEL  = 7;
   localparam int LF_BREAK      = 6;
   localparam int LF_STICKY     = 5;
   localparam int LF_EVEN       = 4;
   localparam int LF_PARITY_ON  = 3;
   localparam int LF_STOP_SEL   = 2;
   localparam int LF_SIZE_HI    = 1;
   localparam int LF_SIZE_LO    = 0;

   // Ticks per bit, mid-bit point and stop lengths.
   localparam logic [5:0] TICKS_PER_BIT  = 6'h10;
   localparam logic [3:0] TICK_BIT_END   = 4'hf;
   localparam logic [3:0] TICK_BIT_MID   = 4'h7;
   localparam logic [5:0] STOP_ONE_TICKS = 6'h10;
   localparam logic [5:0] STOP_HALF_TICKS = 6'h18;
   localparam logic [5:0] STOP_TWO_TICKS = 6'h20;

   // Receive threshold step.
   localparam logic [7:0] TRIG_STEP = 8'h08;

   // Power-up delay before the pin shows readiness.
   localparam int          CLK_PERIOD_NS  = 100;
   localparam int          READY_DELAY_NS = 1000;
   localparam logic [7:0]  READY_CYCLES   = 8'((READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // One received character.
   typedef struct packed {
      logic       ninth;      // Parity error or ninth bit.
      logic       frame_err;
      logic [7:0] data;
   } umlc_rx_word_s;

   // One driven pin: level and active-low output enable.
   typedef struct packed {
      logic level;
      logic oe_b;
   } umlc_pin_s;

endpackage : umlc_pkg

//--- verilog/umlc_channel_ctrl.sv
// Channel mode and line format control with framers.
//
// Summary of operation
// (R1) Reset clears interrupt select; pin signals readiness.
// (R2) Select set: pin is active-low pending interrupt.
// (R3) Auto direction: RTS high while data queued.
// (R4) Pulse transmitter-empty event when fully empty.
// (R5) RTS float bit three-states RTS.
// (R6) TX float bit three-states TX.
// (R7) Inhibit finishes current character, TX idles high.
// (R8) Auto disable sets inhibit when fully empty.
// (R9) Receive inhibit stops accepting new characters.
// (R10) Echo blanking drops data while transmitting, plus hold.
// (R11) Nine-bit mode: no parity, ninth bit reported.
// (R12) Loopback: TX to RX, RTS to CTS, TX pin floated, RTS pin kept at manual level unless clock routed.
// (R13) Up to four match characters raise event.
// (R14) With auto XON/XOFF only second and fourth match.
// (R15) Receive-empty event on drain, or inverted arrival.
// (R16) Threshold event on fill, or inverted drain.
// (R17) Flush bit empties both queues until cleared.
// (R18) Channel reset restores registers, clears queues.
// (R19) Manual RTS level used unless clock routed or auto direction on outside loopback.
// (R20) Break holds TX low while set.
// (R21) Sticky parity forced by even select.
// (R22) Parity even or odd per select.
// (R23) Stop select: one, one and half, two.
// (R24) Word size field selects five to eight.
`timescale 1ns/10ps

module umlc_channel_ctrl
   import umlc_pkg::*;
(
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // Channel register port.
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   // Neighbouring channel settings.
   input  wire logic [3:0]           hold_bits,
   input  wire logic [3:0]           rx_trig_code,
   input  wire logic                 clk_on_rts,
   input  wire logic                 auto_tx_disable,
   input  wire logic                 auto_xon_xoff,
   input  wire logic [3:0]           match_enable,
   input  wire logic [31:0]          match_chars,
   input  wire logic                 irq_pending,
   // Sixteen-per-bit tick and clock to route onto RTS.
   input  wire logic                 os_tick,
   input  wire logic                 rts_clk,
   // Transmit queue.
   input  wire logic                 tx_fifo_empty,
   input  wire logic [7:0]           tx_fifo_data,
   output logic                      tx_fifo_pop,
   // Receive queue.
   output logic                      rx_push,
   output umlc_rx_word_s             rx_word,
   input  wire logic [7:0]           rx_fifo_level,
   input  wire logic                 rx_fifo_pop,
   output logic                      fifo_flush,
   // Interrupt status events.
   output logic                      tx_empty_evt,
   output logic                      match_evt,
   output logic                      receive_empty_irq,
   output logic                      receive_threshold_irq,
   // Pins.
   output logic                      irq_b,
   output umlc_pin_s                 tx_pin,
   output umlc_pin_s                 rts_pin,
   input  wire logic                 rx_i,
   input  wire logic                 cts_b_i,
   output logic                      cts_level
);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_START = 3'b001,
      ST_DATA  = 3'b011,
      ST_PAR   = 3'b010,
      ST_STOP  = 3'b110
   } umlc_state_e;

   // Mask of the data bits in use.
   function automatic logic [7:0] word_mask(input logic [1:0] size);
      word_mask = 8'hff >> (2'h3 - size);
   endfunction : word_mask

   // Parity bit sent or expected.
   function automatic logic parity_bit(input logic [7:0] data, input logic [7:0] lf);
      logic x;
      x = ^(data & word_mask(lf[LF_SIZE_HI:LF_SIZE_LO]));
      if (lf[LF_STICKY]) begin
         parity_bit = ~lf[LF_EVEN]; // R21
      end else begin
         parity_bit = lf[LF_EVEN] ? x : ~x; // R22
      end
   endfunction : parity_bit

   logic [7:0]    mode_one_q;
   logic [7:0]    mode_two_q;
   logic [7:0]    line_fmt_q;
   logic [7:0]    ready_cnt_q;
   logic          chan_rst;
   logic          loopback;
   logic          nine_bit;
   logic          parity_used;
   logic [2:0]    last_bit;
   logic [5:0]    stop_ticks;
   umlc_state_e   tx_state_q;
   logic [5:0]    tx_tick_q;
   logic [2:0]    tx_bit_q;
   logic [7:0]    tx_data_q;
   logic          tx_line_q;
   logic          tx_line;
   logic          tx_start;
   logic          tx_empty_q;
   logic          tx_empty;
   logic [7:0]    hold_cnt_q;
   logic          rts_auto_q;
   umlc_state_e   rx_state_q;
   logic [3:0]    rx_tick_q;
   logic [2:0]    rx_bit_q;
   logic [7:0]    rx_data_q;
   logic          rx_ninth_q;
   logic          rx_src;
   logic          rx_blank;
   logic [7:0]    trig_level;
   logic [3:0]    match_hit;
   logic          rx_done;

   assign chan_rst    = mode_two_q[M2_CHAN_RST];
   assign loopback    = mode_two_q[M2_LOOPBACK];
   assign nine_bit    = mode_two_q[M2_NINE_BIT];
   assign parity_used = line_fmt_q[LF_PARITY_ON] & ~nine_bit; // R11
   assign last_bit    = 3'(3'h4 + {1'b0, line_fmt_q[LF_SIZE_HI:LF_SIZE_LO]}); // R24
   assign trig_level  = 8'(TRIG_STEP * rx_trig_code);

   // Stop length in ticks; with stop select set, five-bit words get one and a half bits.
   always_comb begin
      if (!line_fmt_q[LF_STOP_SEL]) begin
         stop_ticks = STOP_ONE_TICKS; // R23
      end else if (line_fmt_q[LF_SIZE_HI:LF_SIZE_LO] == 2'h0) begin
         stop_ticks = STOP_HALF_TICKS; // R23
      end else begin
         stop_ticks = STOP_TWO_TICKS; // R23
      end
   end

   // Mode one; the auto disable set beats a host write.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_one_q <= MODE_ONE_RST;
      end else if (chan_rst) begin
         mode_one_q <= MODE_ONE_RST; // R1 R18
      end else begin
         if (reg_wr && reg_addr == MODE_ONE_OFS) begin
            mode_one_q <= reg_wdata & MODE_ONE_MASK;
         end
         if (auto_tx_disable && tx_empty && !tx_empty_q) begin
            mode_one_q[M1_TX_INHIB] <= 1'b1; // R8
         end
      end
   end

   // Mode two; the reset bit holds until written to zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_two_q <= MODE_TWO_RST;
      end else if (reg_wr && reg_addr == MODE_TWO_OFS) begin
         mode_two_q <= reg_wdata;
      end else if (chan_rst) begin
         mode_two_q[7:1] <= MODE_TWO_RST[7:1]; // R18
      end
   end

   // Line format register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_fmt_q <= LINE_FMT_RST;
      end else if (chan_rst) begin
         line_fmt_q <= LINE_FMT_RST; // R18
      end else if (reg_wr && reg_addr == LINE_FMT_OFS) begin
         line_fmt_q <= reg_wdata;
      end
   end

   // Registered read data; unmapped offsets read zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            MODE_ONE_OFS: reg_rdata <= mode_one_q;
            MODE_TWO_OFS: reg_rdata <= mode_two_q;
            LINE_FMT_OFS: reg_rdata <= line_fmt_q;
            default:      reg_rdata <= 8'h00;
         endcase
      end
   end

   // Flush is a level, holding the queues empty until cleared.
   assign fifo_flush = mode_two_q[M2_FLUSH] | chan_rst; // R17 R18

   // Power-up counter; channel reset restarts it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ready_cnt_q <= 8'h00;
      end else if (chan_rst) begin
         ready_cnt_q <= 8'h00; // R1
      end else if (ready_cnt_q != READY_CYCLES) begin
         ready_cnt_q <= ready_cnt_q + 8'h01;
      end
   end

   // Interrupt pin: readiness, then pending interrupts once selected.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_b <= 1'b0;
      end else if (mode_one_q[M1_IRQ_SEL]) begin
         irq_b <= ~irq_pending; // R2
      end else begin
         irq_b <= (ready_cnt_q == READY_CYCLES); // R1
      end
   end

   // Start only once auto direction has raised RTS.
   assign tx_start = (tx_state_q == ST_IDLE) && !tx_fifo_empty && !mode_one_q[M1_TX_INHIB] // R7
                     && !line_fmt_q[LF_BREAK] && !chan_rst && !fifo_flush
                     && (!mode_one_q[M1_AUTO_DIR] || rts_auto_q); // R3
   assign tx_fifo_pop = tx_start;

   // Transmit framing; inhibit is checked only between characters.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_state_q <= ST_IDLE;
         tx_tick_q  <= 6'h00;
         tx_bit_q   <= 3'h0;
         tx_data_q  <= 8'h00;
         tx_line_q  <= 1'b1;
      end else if (chan_rst) begin
         tx_state_q <= ST_IDLE;
         tx_line_q  <= 1'b1;
      end else begin
         case (tx_state_q)
            ST_IDLE: begin
               tx_line_q <= 1'b1; // R7
               if (tx_start) begin
                  tx_data_q  <= tx_fifo_data;
                  tx_state_q <= ST_START;
                  tx_tick_q  <= 6'h00;
                  tx_line_q  <= 1'b0;
               end
            end
            ST_START: begin
               if (os_tick) begin
                  tx_tick_q <= tx_tick_q + 6'h01;
                  if (tx_tick_q == TICKS_PER_BIT - 6'h01) begin
                     tx_tick_q  <= 6'h00;
                     tx_bit_q   <= 3'h0;
                     tx_line_q  <= tx_data_q[0];
                     tx_state_q <= ST_DATA;
                  end
               end
            end
            ST_DATA: begin
               if (os_tick) begin
                  tx_tick_q <= tx_tick_q + 6'h01;
                  if (tx_tick_q == TICKS_PER_BIT - 6'h01) begin
                     tx_tick_q <= 6'h00;
                     if (tx_bit_q == last_bit) begin // R24
                        tx_line_q  <= parity_used ? parity_bit(tx_data_q, line_fmt_q) : 1'b1; // R22
                        tx_state_q <= parity_used ? ST_PAR : ST_STOP;
                     end else begin
                        tx_bit_q  <= tx_bit_q + 3'h1;
                        tx_line_q <= tx_data_q[tx_bit_q + 3'h1];
                     end
                  end
               end
            end
            ST_PAR: begin
               if (os_tick) begin
                  tx_tick_q <= tx_tick_q + 6'h01;
                  if (tx_tick_q == TICKS_PER_BIT - 6'h01) begin
                     tx_tick_q  <= 6'h00;
                     tx_line_q  <= 1'b1;
                     tx_state_q <= ST_STOP;
                  end
               end
            end
            ST_STOP: begin
               if (os_tick) begin
                  tx_tick_q <= tx_tick_q + 6'h01;
                  if (tx_tick_q == stop_ticks - 6'h01) begin // R23
                     tx_tick_q  <= 6'h00;
                     tx_state_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               tx_state_q <= ST_IDLE;
               tx_line_q  <= 1'b1;
            end
         endcase
      end
   end

   // Break overrides the framer.
   assign tx_line  = tx_line_q & ~line_fmt_q[LF_BREAK]; // R20
   assign tx_empty = (tx_state_q == ST_IDLE) && tx_fifo_empty;

   // Transmitter-empty edge event.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_empty_q   <= 1'b1;
         tx_empty_evt <= 1'b0;
      end else begin
         tx_empty_q   <= tx_empty;
         tx_empty_evt <= tx_empty && !tx_empty_q && !chan_rst; // R4
      end
   end

   // Hold time after sending, shared by direction control and blanking.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_cnt_q <= 8'h00;
      end else if (chan_rst) begin
         hold_cnt_q <= 8'h00;
      end else if (tx_state_q != ST_IDLE) begin
         hold_cnt_q <= {hold_bits, 4'h0}; // R10
      end else if (os_tick && hold_cnt_q != 8'h00) begin
         hold_cnt_q <= hold_cnt_q - 8'h01;
      end
   end

   // Auto direction: high while data is queued, sent or held.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rts_auto_q <= 1'b0;
      end else begin
         rts_auto_q <= mode_one_q[M1_AUTO_DIR] && !chan_rst
                       && (!tx_fifo_empty || tx_state_q != ST_IDLE || hold_cnt_q != 8'h00); // R3
      end
   end

   // Pin drive; loopback floats TX, keeps manual RTS unless clock routed.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_pin  <= '{level: 1'b1, oe_b: 1'b0};
         rts_pin <= '{level: 1'b0, oe_b: 1'b0};
      end else begin
         tx_pin.level  <= tx_line;
         tx_pin.oe_b   <= mode_one_q[M1_TX_FLOAT] | loopback; // R6 R12
         rts_pin.oe_b  <= mode_one_q[M1_RTS_FLOAT]; // R5
         if (clk_on_rts) begin
            rts_pin.level <= rts_clk;
         end else if (mode_one_q[M1_AUTO_DIR] && !loopback) begin
            rts_pin.level <= rts_auto_q; // R3
         end else begin
            rts_pin.level <= line_fmt_q[LF_RTS_LEVEL]; // R19 R12
         end
      end
   end

   // CTS seen by the channel; RTS feeds it in loopback.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cts_level <= 1'b0;
      end else begin
         cts_level <= loopback ? rts_pin.level : ~cts_b_i; // R12
      end
   end

   // Receive source and gating; blanking covers the hold time too.
   assign rx_src   = loopback ? tx_line : rx_i; // R12
   assign rx_blank = mode_two_q[M2_ECHO_BLANK] && (tx_state_q != ST_IDLE || hold_cnt_q != 8'h00); // R10
   assign rx_done  = os_tick && rx_state_q == ST_STOP && rx_tick_q == TICK_BIT_END;

   // Receive framing; mid-bit samples, first stop bit only.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_state_q <= ST_IDLE;
         rx_tick_q  <= 4'h0;
         rx_bit_q   <= 3'h0;
         rx_data_q  <= 8'h00;
         rx_ninth_q <= 1'b0;
      end else if (chan_rst) begin
         rx_state_q <= ST_IDLE;
      end else if (os_tick) begin
         rx_tick_q <= rx_tick_q + 4'h1;
         case (rx_state_q)
            ST_IDLE: begin
               if (!rx_src && !mode_one_q[M1_RX_INHIB] && !rx_blank) begin // R9 R10
                  rx_state_q <= ST_START;
                  rx_tick_q  <= 4'h0;
                  rx_data_q  <= 8'h00;
               end
            end
            ST_START: begin
               if (rx_tick_q == TICK_BIT_MID) begin
                  rx_tick_q  <= 4'h0;
                  rx_bit_q   <= 3'h0;
                  rx_state_q <= rx_src ? ST_IDLE : ST_DATA;
               end
            end
            ST_DATA: begin
               if (rx_tick_q == TICK_BIT_END) begin
                  rx_data_q[rx_bit_q] <= rx_src;
                  rx_bit_q            <= rx_bit_q + 3'h1;
                  if (rx_bit_q == last_bit) begin // R24
                     rx_state_q <= (parity_used || nine_bit) ? ST_PAR : ST_STOP;
                  end
               end
            end
            ST_PAR: begin
               if (rx_tick_q == TICK_BIT_END) begin
                  rx_ninth_q <= rx_src;
                  rx_state_q <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (rx_tick_q == TICK_BIT_END) begin
                  rx_state_q <= ST_IDLE;
               end
            end
            default: begin
               rx_state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Match compare; auto XON/XOFF leaves only the second and fourth slots.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         match_hit[i] = match_enable[i] && (match_chars[8*i +: 8] == rx_data_q)
                        && (!auto_xon_xoff || i == 1 || i == 3); // R13 R14
      end
   end

   // Store the character; inhibit or blanking at the end drops it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_push   <= 1'b0;
         rx_word   <= '0;
         match_evt <= 1'b0;
      end else begin
         rx_push   <= 1'b0;
         match_evt <= 1'b0;
         if (rx_done && !mode_one_q[M1_RX_INHIB] && !rx_blank && !chan_rst && !fifo_flush) begin // R9 R10
            rx_push         <= 1'b1;
            rx_word.data    <= rx_data_q & word_mask(line_fmt_q[LF_SIZE_HI:LF_SIZE_LO]);
            rx_word.frame_err <= ~rx_src;
            if (nine_bit) begin
               rx_word.ninth <= rx_ninth_q; // R11
            end else begin
               rx_word.ninth <= parity_used && (rx_ninth_q != parity_bit(rx_data_q, line_fmt_q)); // R22
            end
            match_evt <= mode_two_q[M2_MATCH_EN] && (|match_hit); // R13
         end
      end
   end

   // Queue level events; invert bits pick the opposite edge.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         receive_empty_irq     <= 1'b0;
         receive_threshold_irq <= 1'b0;
      end else if (chan_rst) begin
         receive_empty_irq     <= 1'b0;
         receive_threshold_irq <= 1'b0;
      end else begin
         if (mode_two_q[M2_EMPTY_INV]) begin
            receive_empty_irq <= rx_push && rx_fifo_level == 8'h00; // R15
         end else begin
            receive_empty_irq <= rx_fifo_pop && !rx_push && rx_fifo_level == 8'h01; // R15
         end
         if (mode_two_q[M2_TRIG_INV]) begin
            receive_threshold_irq <= rx_fifo_pop && !rx_push && rx_fifo_level == trig_level + 8'h01; // R16
         end else begin
            receive_threshold_irq <= rx_push && !rx_fifo_pop && rx_fifo_level == trig_level - 8'h01; // R16
         end
      end
   end

endmodule : umlc_channel_ctrl

//--- test/umlc_asserts.sv
// Checks on the channel block ports.
`timescale 1ns/10ps
module umlc_asserts
   import umlc_pkg::*;
(
   // Watched ports.
   input wire logic       clk, rst_b, tx_fifo_pop, rx_push, rx_fifo_pop, fifo_flush, tx_empty_evt, match_evt,
   input wire logic       receive_empty_irq, receive_threshold_irq, irq_b,
   input wire logic [3:0] rx_trig_code,
   input wire logic [7:0] rx_fifo_level,
   input wire umlc_pin_s  tx_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Trigger level, eight per code step.
   logic [7:0] trig_lvl;
   assign trig_lvl = {1'b0, rx_trig_code, 3'b000};
   // Start bit shows two edges after the pop.
   sequence s_start_bit;
      ##2 !tx_pin.level;
   endsequence
   chk_start_bit: assert property (tx_fifo_pop |-> s_start_bit)
      else $error("no start bit after pop");
   chk_char_gap: assert property (tx_fifo_pop |=> !tx_fifo_pop [*8])
      else $error("pop inside a character");
   chk_ready_delay: assert property ($rose(rst_b) |-> !irq_b [*8])
      else $error("irq pin rose early");
   chk_flush_hold: assert property (fifo_flush |-> !tx_fifo_pop)
      else $error("pop during flush");
   chk_match_push: assert property (match_evt |-> rx_push)
      else $error("match without push");
   chk_empty_idle: assert property (tx_empty_evt |-> tx_pin.level)
      else $error("tx empty with line low");
   chk_empty_cause: assert property (receive_empty_irq |->
      $past(rx_fifo_pop && !rx_push && rx_fifo_level == 8'h01) || $past(rx_push && rx_fifo_level == 8'h00))
      else $error("receive empty event without cause");
   chk_trig_cause: assert property (receive_threshold_irq |->
      $past(rx_push && !rx_fifo_pop && rx_fifo_level == trig_lvl - 8'h01)
      || $past(rx_fifo_pop && !rx_push && rx_fifo_level == trig_lvl + 8'h01))
      else $error("threshold event without cause");
endmodule : umlc_asserts

//--- test/umlc_line_model.sv
// Far-end sender of 8N1 characters.
`timescale 1ns/10ps
module umlc_line_model (
   // Clock and send command.
   input  wire logic       clk,
   input  wire logic       send,
   input  wire logic [7:0] data,
   // Serial line.
   output logic            rx_o
);
   logic [9:0] frame;
   initial rx_o = 1'b1;
   // Sixteen clocks a bit; the line idles high.
   always @(posedge clk) begin
      if (send) begin
         frame = {1'b1, data, 1'b0};
         for (int i = 0; i < 10; i++) begin
            rx_o <= frame[i];
            repeat (16) @(posedge clk);
         end
      end
   end
endmodule : umlc_line_model

//--- test/testbench.sv
// Bench for the channel block.
`timescale 1ns/10ps
module testbench;
   import umlc_pkg::*;
   logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, tx_fifo_empty = 1, rx_fifo_pop = 0, irq_pending = 0;
   logic rts_clk = 0, send = 0, tx_on = 0, tx_fifo_pop, rx_push, fifo_flush, tx_empty_evt, match_evt;
   logic receive_empty_irq, receive_threshold_irq, irq_b, rx_i, cts_level;
   logic [7:0] reg_addr = 0, reg_wdata = 0, tx_fifo_data = 0, rx_fifo_level = 0, sdata = 0, v, tx_b, reg_rdata;
   logic [3:0] hold_bits = 0, rx_trig_code = 0, match_enable = 0;
   logic [31:0] match_chars = 0, rnd = 32'h1f1237dc;
   umlc_rx_word_s rx_word;
   umlc_pin_s tx_pin, rts_pin;
   logic [7:0] tx_q[$], rx_q[$];
   int fail_count = 0, comparisons = 0;
   umlc_channel_ctrl dut (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .hold_bits,
      .rx_trig_code, .clk_on_rts(1'b0), .auto_tx_disable(1'b0), .auto_xon_xoff(1'b0), .match_enable,
      .match_chars, .irq_pending, .os_tick(1'b1), .rts_clk, .tx_fifo_empty, .tx_fifo_data, .tx_fifo_pop,
      .rx_push, .rx_word, .rx_fifo_level, .rx_fifo_pop, .fifo_flush, .tx_empty_evt, .match_evt,
      .receive_empty_irq, .receive_threshold_irq, .irq_b, .tx_pin, .rts_pin, .rx_i, .cts_b_i(1'b0), .cts_level);
   umlc_line_model far (.clk, .send, .data(sdata), .rx_o(rx_i));
   always #50 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic stop_test();
      if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      cyc(1);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      cyc(1);
      {reg_rd, reg_addr} = {1'b1, a};
      cyc(1);
      reg_rd = 1'b0;
      check("register", reg_rdata, e);
   endtask : rd_chk
   task automatic tx_send(input logic [7:0] d);
      cyc(1);
      tx_q.push_back(d);
      {tx_fifo_data, tx_fifo_empty} = {d, 1'b0};
      for (int i = 0; i < 300 && tx_fifo_pop !== 1'b1; i++) @(negedge clk);
      cyc(1);
      tx_fifo_empty = 1'b1;
   endtask : tx_send
   task automatic rx_send(input logic [7:0] d, input logic keep);
      if (keep) rx_q.push_back(d);
      {match_chars, sdata, send} = {{4{d}}, d, 1'b1};
      cyc(1);
      send = 1'b0;
      cyc(200);
   endtask : rx_send
   // Random settings and queue status every cycle.
   always begin
      cyc(1);
      rnd = xs(rnd);
      {rx_fifo_pop, rx_fifo_level, rx_trig_code, hold_bits} = {rnd[7], 1'b0, rnd[6:0], rnd[11:8], rnd[15:12]};
      {match_enable, irq_pending, rts_clk} = {rnd[19:16] | 4'h1, rnd[20], rnd[21]};
   end
   // Decode TX at mid-bit; an unqueued character is an error.
   always @(negedge tx_pin.level) begin
      if (tx_on) begin
         repeat (8) @(negedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (16) @(negedge clk);
            tx_b[i] = tx_pin.level;
         end
         if (tx_q.size() == 0) check("tx_extra", 8'h01, 8'h00);
         else check("tx_data", tx_b, tx_q.pop_front());
      end
   end
   // Stored characters against the oldest note.
   always @(negedge clk) begin
      if (rx_push === 1'b1) begin
         if (rx_q.size() == 0) check("rx_extra", 8'h01, 8'h00);
         else check("rx_data", rx_word.data, rx_q.pop_front());
         check("match", 8'(match_evt), 8'(rx_q.size() == 0));
      end
   end
   // About 1200 cycles are needed; 6000 means a hang.
   initial begin
      #600000;
      fail_count++;
      stop_test();
   end
   initial begin
      cyc(3);
      rst_b = 1'b1;
      cyc(20);
      for (int i = 0; i < 4; i++) rd_chk(8'(9 + i), (i == 2) ? 8'h05 : 8'h00);
      wr(8'h09, 8'hff);
      rd_chk(8'h09, 8'h9f);
      wr(8'h09, 8'h08);
      cyc(2);
      check("rts_oe", 8'(rts_pin.oe_b), 8'h01);
      wr(8'h09, 8'h04);
      cyc(2);
      check("tx_oe", 8'(tx_pin.oe_b), 8'h01);
      wr(8'h09, 8'h00);
      v = rnd[7:0];
      wr(8'h0b, v);
      rd_chk(8'h0b, v);
      wr(8'h0b, 8'hc3);
      cyc(2);
      check("rts_level", 8'(rts_pin.level), 8'h01);
      check("break", 8'(tx_pin.level), 8'h00);
      wr(8'h0a, 8'h01);
      wr(8'h0b, 8'h1f);
      rd_chk(8'h0b, 8'h05);
      check("flush", 8'(fifo_flush), 8'h01);
      wr(8'h0a, 8'h00);
      check("irq_low", 8'(irq_b), 8'h00);
      cyc(15);
      check("irq_ready", 8'(irq_b), 8'h01);
      wr(8'h0a, 8'h02);
      tx_fifo_empty = 1'b0;
      cyc(5);
      tx_fifo_empty = 1'b1;
      wr(8'h0a, 8'h10);
      wr(8'h0b, 8'h03);
      tx_on = 1'b1;
      repeat (3) tx_send(rnd[7:0]);
      cyc(40);
      wr(8'h09, 8'h02);
      tx_fifo_empty = 1'b0;
      cyc(300);
      check("tx_idle", 8'(tx_pin.level), 8'h01);
      tx_fifo_empty = 1'b1;
      wr(8'h09, 8'h00);
      rx_send(rnd[7:0], 1'b1);
      wr(8'h09, 8'h01);
      rx_send(rnd[7:0], 1'b0);
      check("queues_left", 8'(tx_q.size() + rx_q.size()), 8'h00);
      stop_test();
   end
endmodule : testbench
bind umlc_channel_ctrl umlc_asserts u_chk (.clk, .rst_b, .tx_fifo_pop, .rx_push, .rx_fifo_pop, .fifo_flush,
   .tx_empty_evt, .match_evt, .receive_empty_irq, .receive_threshold_irq, .irq_b, .rx_trig_code,
   .rx_fifo_level, .tx_pin);
